// ===== line_locked_clock.v
`timescale 1ns/100ps
`default_nettype none
`include "line_clock_consts.vh"

// Contract
// - sample clock and both data clocks come from the loop, data clocks aligned
// - loop reference is the input line sync, polarity chosen by a bit
// - clocks run at line rate times divide value plus one; 12-bit split
// - feedback divider supports ratios 2 through 4095
// - two-bit band field picks oscillator range: 00/01 low, 10 mid, 11 high
// - three-bit pump field maps codes to 50..1500 microamps in order
// - band and pump fields live together in the register at 0x0C
// - five-bit phase delays sample clock in 32 steps; data clocks follow
// - while flywheel hold is high, the loop ignores sync and keeps its frequency
// - line sync output is always active high
// - hold low: output rises few pixels after lead, falls at trailing edge or at half period, whichever comes first
// - hold high, sync high: rise on loop timing, fall at half period
// - hold high, sync toggling: rise on loop timing, fall at trailing edge or at half period, whichever comes first
// - hold high, sync low: output held low
module line_locked_clock (
	input wire core_clk,
	input wire reset,
	input wire clk_en,
	input wire line_sync_in,
	input wire flywheel_hold,
	input wire [7:0] reg_ptr,
	input wire reg_wr_en,
	input wire [7:0] reg_wr_data,
	output reg [7:0] reg_rd_data_q,
	output reg pll_pixel_clock_q,
	output reg sample_clock_q,
	output reg data_out_clock_q,
	output reg data_out_clock_n_q,
	output reg line_sync_out_q,
	output reg [1:0] vco_band_sel_q,
	output reg [1:0] vco_range_q,
	output reg [2:0] pump_current_sel_q,
	output reg [10:0] pump_current_ua_q,
	output reg loop_locked_q
);

// ==================================================================
// registers
reg [11:0] line_divide_value_q;
reg [4:0] sample_phase_sel_q;
reg sync_polarity_sel_q;
reg hold_meta_q;
reg hold_q;

wire hs_active;
wire hs_lead;
wire hs_trail;

line_sync_front u_front (
	.core_clk(core_clk),
	.reset(reset),
	.clk_en(clk_en),
	.line_sync_in(line_sync_in),
	.sync_polarity_sel(sync_polarity_sel_q),
	.hs_active_q(hs_active),
	.lead_pulse_q(hs_lead),
	.trail_pulse_q(hs_trail)
);

localparam [7:0] cfg_rst_val = `PLL_CFG_RESET;

always @(posedge core_clk) begin
	if (reset) begin
		line_divide_value_q <= `DIV_RESET;
		sample_phase_sel_q <= `PHASE_RESET;
		vco_band_sel_q <= cfg_rst_val[`VCO_BAND_HI:`VCO_BAND_LO];
		pump_current_sel_q <= cfg_rst_val[`PUMP_HI:`PUMP_LO];
		sync_polarity_sel_q <= `POL_RESET;
	end else if (clk_en && reg_wr_en) begin
		if (reg_ptr == `REG_DIV_HIGH) begin
			line_divide_value_q[11:4] <= reg_wr_data;
		end else if (reg_ptr == `REG_DIV_LOW) begin
			line_divide_value_q[3:0] <= reg_wr_data[3:0];
		end else if (reg_ptr == `REG_PHASE) begin
			sample_phase_sel_q <= reg_wr_data[4:0];
		end else if (reg_ptr == `REG_PLL_LOOP_CONFIG) begin
			vco_band_sel_q <= reg_wr_data[`VCO_BAND_HI:`VCO_BAND_LO];
			pump_current_sel_q <= reg_wr_data[`PUMP_HI:`PUMP_LO];
		end else if (reg_ptr == `REG_SYNC_CTRL) begin
			sync_polarity_sel_q <= reg_wr_data[`POL_BIT];
		end
	end
end

reg [7:0] rd_d;

always @* begin
	rd_d = 8'h00;
	if (reg_ptr == `REG_DIV_HIGH) begin
		rd_d = line_divide_value_q[11:4];
	end else if (reg_ptr == `REG_DIV_LOW) begin
		rd_d = {4'h0, line_divide_value_q[3:0]};
	end else if (reg_ptr == `REG_PHASE) begin
		rd_d = {3'h0, sample_phase_sel_q};
	end else if (reg_ptr == `REG_PLL_LOOP_CONFIG) begin
		rd_d = {vco_band_sel_q, pump_current_sel_q, 3'h0};
	end else if (reg_ptr == `REG_SYNC_CTRL) begin
		rd_d = {7'h00, sync_polarity_sel_q};
	end else if (reg_ptr == `REG_STATUS) begin
		rd_d = {6'h00, hold_q, loop_locked_q};
	end
end

// ==================================================================
// band and pump decode
reg [10:0] pump_ua_d;

always @* begin
	case (pump_current_sel_q)
	3'h0: pump_ua_d = `PUMP_UA_0;
	3'h1: pump_ua_d = `PUMP_UA_1;
	3'h2: pump_ua_d = `PUMP_UA_2;
	3'h3: pump_ua_d = `PUMP_UA_3;
	3'h4: pump_ua_d = `PUMP_UA_4;
	3'h5: pump_ua_d = `PUMP_UA_5;
	3'h6: pump_ua_d = `PUMP_UA_6;
	default: pump_ua_d = `PUMP_UA_7;
	endcase
end

always @(posedge core_clk) begin
	if (reset) begin
		reg_rd_data_q <= 8'h00;
		vco_range_q <= 2'h0;
		pump_current_ua_q <= `PUMP_UA_4;
		hold_meta_q <= 1'b0;
		hold_q <= 1'b0;
	end else if (clk_en) begin
		reg_rd_data_q <= rd_d;
		// codes 00 and 01 share the low range
		vco_range_q <= vco_band_sel_q[1] ? {1'b1, vco_band_sel_q[0]} :
			2'h0;
		pump_current_ua_q <= pump_ua_d;
		hold_meta_q <= flywheel_hold;
		hold_q <= hold_meta_q;
	end
end

// ==================================================================
// line period measurement
reg [`LINE_PER_W-1:0] per_cnt_q;
reg [`LINE_PER_W-1:0] line_period_q;

always @(posedge core_clk) begin
	if (reset) begin
		per_cnt_q <= {`LINE_PER_W{1'b0}};
		line_period_q <= {`LINE_PER_W{1'b0}};
		loop_locked_q <= 1'b0;
	end else if (clk_en) begin
		if (hs_lead && !hold_q) begin
			line_period_q <= per_cnt_q + 1'b1;
			per_cnt_q <= {`LINE_PER_W{1'b0}};
			loop_locked_q <= 1'b1;
		end else if (per_cnt_q != `LINE_PER_MAX) begin
			per_cnt_q <= per_cnt_q + 1'b1;
		end
	end
end

// ==================================================================
// feedback divider as a phase accumulator over two half periods
// limitation: needs 2*(ratio) core cycles per line at least
reg [11:0] ratio_m1;

always @* begin
	ratio_m1 = line_divide_value_q;
	if (line_divide_value_q < `DIV_MIN) begin
		ratio_m1 = `DIV_MIN;
	end else if (line_divide_value_q > `DIV_MAX) begin
		ratio_m1 = `DIV_MAX;
	end
end

wire [12:0] ratio = {1'b0, ratio_m1} + 13'h0001;
wire [20:0] two_p = {line_period_q, 1'b0};
wire [20:0] step = {7'h00, ratio, 1'b0};
reg [20:0] pos_q;
reg [11:0] pix_cnt_q;
wire [21:0] pos_sum = {1'b0, pos_q} + {1'b0, step};
wire pos_wrap = pos_sum >= {1'b0, two_p};
wire [20:0] pos_next = pos_wrap ? pos_sum[20:0] - two_p : pos_sum[20:0];
wire pix_last = {1'b0, pix_cnt_q} == ratio - 13'h0001;
wire pll_line_start = pos_wrap && pix_last && loop_locked_q;
// last pixel of the first half, so the fall lands at half the line
wire half_line = {1'b0, pix_cnt_q} == (ratio >> 1) - 13'h0001;

always @(posedge core_clk) begin
	if (reset) begin
		pos_q <= 21'h000000;
		pix_cnt_q <= 12'h000;
	end else if (clk_en && loop_locked_q) begin
		if (hs_lead && !hold_q) begin
			// phase update from the reference edge
			pos_q <= 21'h000000;
			pix_cnt_q <= 12'h000;
		end else begin
			pos_q <= pos_next;
			if (pos_wrap) begin
				pix_cnt_q <= pix_last ? 12'h000 : pix_cnt_q + 1'b1;
			end
		end
	end
end

// ==================================================================
// phase shifted sample clock, each step 1/32 of a pixel period
wire [24:0] off_prod = {20'h00000, sample_phase_sel_q} *
	{5'h00, line_period_q};
wire [20:0] off = off_prod[24:4];
wire [20:0] spos = (pos_q >= off) ? pos_q - off : pos_q + two_p - off;

always @(posedge core_clk) begin
	if (reset) begin
		pll_pixel_clock_q <= 1'b0;
		sample_clock_q <= 1'b0;
		data_out_clock_q <= 1'b0;
		data_out_clock_n_q <= 1'b1;
	end else if (clk_en) begin
		pll_pixel_clock_q <= loop_locked_q && (pos_q < two_p >> 1);
		sample_clock_q <= loop_locked_q && (spos < two_p >> 1);
		// data clocks from the same term keep them aligned
		data_out_clock_q <= loop_locked_q && (spos < two_p >> 1);
		data_out_clock_n_q <= !(loop_locked_q && (spos < two_p >> 1));
	end
end

// ==================================================================
// line sync output, active high whatever the input polarity
reg [2:0] dly_cnt_q;
reg rise_pend_q;

always @(posedge core_clk) begin
	if (reset) begin
		line_sync_out_q <= 1'b0;
		dly_cnt_q <= 3'h0;
		rise_pend_q <= 1'b0;
	end else if (clk_en) begin
		if (!hold_q) begin
			if (hs_lead) begin
				rise_pend_q <= 1'b1;
				dly_cnt_q <= `SYNC_OUT_DELAY_PIX;
			end else if (rise_pend_q && pos_wrap) begin
				if (dly_cnt_q == 3'h1) begin
					rise_pend_q <= 1'b0;
					line_sync_out_q <= hs_active;
				end
				dly_cnt_q <= dly_cnt_q - 1'b1;
			end
			if (hs_trail) begin
				// no added delay on the trailing edge
				line_sync_out_q <= 1'b0;
				rise_pend_q <= 1'b0;
			end else if (half_line && pos_wrap && !hs_lead) begin
				line_sync_out_q <= 1'b0;
			end
		end else begin
			rise_pend_q <= 1'b0;
			if (!hs_active) begin
				line_sync_out_q <= 1'b0;
			end else if (pll_line_start) begin
				line_sync_out_q <= 1'b1;
			end else if (half_line && pos_wrap) begin
				line_sync_out_q <= 1'b0;
			end
		end
	end
end

endmodule // line_locked_clock

`default_nettype wire

// ===== line_clock_consts.vh
`ifndef LINE_CLOCK_CONSTS_VH
`define LINE_CLOCK_CONSTS_VH

// ==================================================================
// register pointers
`define REG_DIV_HIGH 8'h01
`define REG_DIV_LOW 8'h02
`define REG_PHASE 8'h03
`define REG_PLL_LOOP_CONFIG 8'h0C
`define REG_SYNC_CTRL 8'h0E
`define REG_STATUS 8'h10

// ==================================================================
// field positions
`define VCO_BAND_HI 7
`define VCO_BAND_LO 6
`define PUMP_HI 5
`define PUMP_LO 3
`define POL_BIT 0
`define STAT_LOCKED_BIT 0
`define STAT_FLYWHEEL_HOLD_BIT 1

// ==================================================================
// reset values
`define DIV_RESET 12'h31F
`define PHASE_RESET 5'h00
`define PLL_CFG_RESET 8'h60
`define POL_RESET 1'b1

// ==================================================================
// divider span and timing
`define DIV_MIN 12'h001
`define DIV_MAX 12'hFFE
`define LINE_PER_W 20
`define LINE_PER_MAX 20'hFFFFF
`define SYNC_OUT_DELAY_PIX 3'h3

// ==================================================================
// pump current in microamps per code
`define PUMP_UA_0 11'h032
`define PUMP_UA_1 11'h064
`define PUMP_UA_2 11'h096
`define PUMP_UA_3 11'h0FA
`define PUMP_UA_4 11'h15E
`define PUMP_UA_5 11'h1F4
`define PUMP_UA_6 11'h2EE
`define PUMP_UA_7 11'h5DC

`endif

// ===== line_sync_front.v
`timescale 1ns/100ps
`default_nettype none

// ==================================================================
// input sync conditioning: synchronise, fold polarity, find edges
module line_sync_front (
	input wire core_clk,
	input wire reset,
	input wire clk_en,
	input wire line_sync_in,
	input wire sync_polarity_sel,
	output reg hs_active_q,
	output reg lead_pulse_q,
	output reg trail_pulse_q
);

reg meta_q;
reg sync_q;

wire hs_now = sync_q ~^ sync_polarity_sel;

always @(posedge core_clk) begin
	if (reset) begin
		meta_q <= 1'b0;
		sync_q <= 1'b0;
		hs_active_q <= 1'b0;
		lead_pulse_q <= 1'b0;
		trail_pulse_q <= 1'b0;
	end else if (clk_en) begin
		meta_q <= line_sync_in;
		sync_q <= meta_q;
		hs_active_q <= hs_now;
		lead_pulse_q <= hs_now & ~hs_active_q;
		trail_pulse_q <= ~hs_now & hs_active_q;
	end
end

endmodule // line_sync_front

`default_nettype wire

// ===== sync_source.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// line sync source: mode 0 pulses, 1 stuck high, 2 stuck low
module sync_source (
	input wire logic core_clk,
	input wire logic [15:0] period,
	input wire logic [15:0] width,
	input wire logic [1:0] mode,
	input wire logic invert,
	output var logic line_sync_in
);
	logic [15:0] cnt_q = 16'h0000;
	logic level;
	// moves on the falling edge so the pin never races the sampling edge
	always @(negedge core_clk) begin
		cnt_q <= (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
	end
	always_comb begin
		case (mode)
		2'h1: level = 1'b1;
		2'h2: level = 1'b0;
		default: level = cnt_q < width;
		endcase
	end
	always_comb line_sync_in = level ^ invert;
endmodule // sync_source
`default_nettype wire

// ===== line_locked_clock_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "line_clock_consts.vh"
// ==========
// port checker
module line_locked_clock_chk (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic line_sync_in,
	input wire logic flywheel_hold,
	input wire logic [7:0] reg_ptr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data_q,
	input wire logic pll_pixel_clock_q,
	input wire logic sample_clock_q,
	input wire logic data_out_clock_q,
	input wire logic data_out_clock_n_q,
	input wire logic line_sync_out_q,
	input wire logic [1:0] vco_band_sel_q,
	input wire logic [1:0] vco_range_q,
	input wire logic [2:0] pump_current_sel_q,
	input wire logic [10:0] pump_current_ua_q,
	input wire logic loop_locked_q
);
	logic [10:0] ua [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
		11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
	logic [4:0] wr_field;
	logic cfg_sel;
	assign wr_field = reg_wr_data[7:3];
	assign cfg_sel = clk_en && reg_ptr == `REG_PLL_LOOP_CONFIG;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	dck_align_a: assert property (
		data_out_clock_q == sample_clock_q) else $error("data clock skew");
	dck_pair_a: assert property (
		data_out_clock_n_q != data_out_clock_q) else $error("pair not inverse");
	band_range_a: assert property (
		vco_range_q == ($past(vco_band_sel_q[1]) ? $past(vco_band_sel_q) : 2'h0))
		else $error("wrong band range");
	pump_current_a: assert property (
		pump_current_ua_q == ua[$past(pump_current_sel_q)])
		else $error("wrong pump current");
	cfg_write_a: assert property (
		cfg_sel && reg_wr_en |=> {vco_band_sel_q, pump_current_sel_q}
		== $past(wr_field)) else $error("config write lost");
	// reads lag the pointer by one edge
	cfg_read_a: assert property (
		cfg_sel |=> reg_rd_data_q == {$past(vco_band_sel_q),
		$past(pump_current_sel_q), 3'h0}) else $error("config read wrong");
	clocks_idle_a: assert property (
		!loop_locked_q |-> !pll_pixel_clock_q && !sample_clock_q)
		else $error("clock before lock");
	sync_trail_a: assert property (
		$fell(line_sync_in) |-> ##[1:5] !line_sync_out_q)
		else $error("sync out late fall");
	flywheel_hold_low_a: assert property (
		(flywheel_hold && !line_sync_in)[*8] |-> !line_sync_out_q)
		else $error("sync out high while input low");
	cover property ($rose(loop_locked_q));
	cover property ($rose(line_sync_out_q) && flywheel_hold);
	cover property ($fell(line_sync_out_q) && line_sync_in);
endmodule // line_locked_clock_chk
bind line_locked_clock line_locked_clock_chk i_line_locked_clock_chk (.*);
`default_nettype wire

// ===== line_locked_clock_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "line_clock_consts.vh"
module line_locked_clock_test;
	logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, flywheel_hold = 1'b0;
	logic reg_wr_en = 1'b0, invert = 1'b0, line_sync_in, loop_locked_q;
	logic [7:0] reg_ptr = 8'h00, reg_wr_data = 8'h00, reg_rd_data_q;
	logic [15:0] period = 16'h0040, width = 16'h0018;
	logic [1:0] mode = 2'h0, vco_band_sel_q, vco_range_q;
	logic pll_pixel_clock_q, sample_clock_q, data_out_clock_q;
	logic data_out_clock_n_q, line_sync_out_q;
	logic [2:0] pump_current_sel_q;
	logic [10:0] pump_current_ua_q;
	int fail_count = 0, checked = 0, pix, hi, skew, rises;
	logic [10:0] ua_tab [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
		11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};
	line_locked_clock i_line_locked_clock (.*);
	sync_source i_sync_source (.*);
	// ==========
	// helpers
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		@(negedge core_clk);
		reg_ptr = p;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		@(negedge core_clk);
		reg_ptr = p;
		repeat (2) @(negedge core_clk);
		check(reg_rd_data_q, e);
	endtask
	task automatic lines(input int k);
		repeat (k * period) @(negedge core_clk);
	endtask
	task automatic measure(input int n);
		logic pd, od;
		pix = 0;
		hi = 0;
		skew = 0;
		rises = 0;
		pd = pll_pixel_clock_q;
		od = line_sync_out_q;
		repeat (n) begin
			@(negedge core_clk);
			pix += (pll_pixel_clock_q && !pd);
			rises += (line_sync_out_q && !od);
			hi += line_sync_out_q;
			skew += (sample_clock_q !== pll_pixel_clock_q);
			pd = pll_pixel_clock_q;
			od = line_sync_out_q;
		end
	endtask
	task automatic final_report;
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_cfg;
		for (int c = 0; c < 32; c++) begin
			wr(`REG_PLL_LOOP_CONFIG, {c[4:0], 3'h0});
			rd(`REG_PLL_LOOP_CONFIG, {c[4:0], 3'h0});
			check(vco_range_q, c[4] ? c[4:3] : 2'h0);
			check(pump_current_ua_q, ua_tab[c[2:0]]);
		end
		wr(`REG_PLL_LOOP_CONFIG, 8'h60);
	endtask
	task automatic t_ratio(input logic [11:0] n, input int exp);
		wr(`REG_DIV_HIGH, n[11:4]);
		wr(`REG_DIV_LOW, {4'h0, n[3:0]});
		lines(4);
		measure(256);
		check(pix, exp);
	endtask
	task automatic t_phase(input logic [7:0] ph, input int exp);
		wr(`REG_PHASE, ph);
		lines(2);
		measure(256);
		check(skew, exp);
	endtask
	task automatic t_out(input logic h, input logic [1:0] m, input logic iv,
		input int r, input int lo, input int up);
		flywheel_hold = h;
		mode = m;
		invert = iv;
		wr(`REG_SYNC_CTRL, {7'h00, !iv});
		lines(3);
		measure(256);
		check(rises, r);
		check(hi >= lo && hi <= up, 1'b1);
	endtask
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// about eleven times the expected run
	initial begin
		repeat (60000) @(posedge core_clk);
		fail_count++;
		final_report();
	end
	initial begin
		repeat (16) @(negedge core_clk);
		reset = 1'b0;
		rd(`REG_DIV_HIGH, 8'h31);
		rd(`REG_DIV_LOW, 8'h0F);
		rd(`REG_PHASE, 8'h00);
		rd(`REG_SYNC_CTRL, 8'h01);
		rd(8'h20, 8'h00);
		check(pump_current_ua_q, 11'h15E);
		t_cfg();
		check(loop_locked_q, 1'b1);
		t_ratio(12'h00F, 64);
		t_ratio(12'h01F, 128);
		t_ratio(12'h000, 8);
		t_ratio(12'h00F, 64);
		t_phase(8'h10, 256);
		t_phase(8'h00, 0);
		t_out(1'b0, 2'h0, 1'b0, 4, 16, 96);
		t_out(1'b0, 2'h0, 1'b1, 4, 16, 96);
		t_out(1'b1, 2'h1, 1'b0, 4, 112, 144);
		t_out(1'b1, 2'h2, 1'b0, 0, 0, 0);
		mode = 2'h0;
		period = 16'h0050;
		lines(3);
		measure(256);
		check(pix, 64);
		final_report();
	end
endmodule // line_locked_clock_test
`default_nettype wire
